/* hdl/spc_pkg.sv */
// spc_pkg: offsets, field positions and reset values of the per-port control registers 1 and 2
// assumes an 8-bit register port addressed by byte offset
package spc_pkg;
  localparam int unsigned NUM_PORTS = 3;
  // register offsets, one pair per port
  localparam logic [7:0] P1_MIRROR_VLAN_CTRL_OFS = 8'h11;
  localparam logic [7:0] P1_FILTER_FLOW_CTRL_OFS = 8'h12;
  localparam logic [7:0] P2_MIRROR_VLAN_CTRL_OFS = 8'h21;
  localparam logic [7:0] P2_FILTER_FLOW_CTRL_OFS = 8'h22;
  localparam logic [7:0] P3_MIRROR_VLAN_CTRL_OFS = 8'h31;
  localparam logic [7:0] P3_FILTER_FLOW_CTRL_OFS = 8'h32;
  // control 1 fields
  localparam int unsigned C1_SNIFFER_BIT  = 7;
  localparam int unsigned C1_RX_SNIFF_BIT = 6;
  localparam int unsigned C1_TX_SNIFF_BIT = 5;
  localparam int unsigned C1_DBL_TAG_BIT  = 4;
  localparam int unsigned C1_RSVD_BIT     = 3;
  localparam int unsigned C1_MEMBER_LSB   = 0;
  localparam int unsigned C1_MEMBER_W     = 3;
  // control 2 fields
  localparam int unsigned C2_RSVD_BIT      = 7;
  localparam int unsigned C2_IN_FILTER_BIT = 6;
  localparam int unsigned C2_DROP_NPVID_BIT = 5;
  localparam int unsigned C2_FORCE_FC_BIT  = 4;
  localparam int unsigned C2_BACKPRES_BIT  = 3;
  localparam int unsigned C2_TX_EN_BIT     = 2;
  localparam int unsigned C2_RX_EN_BIT     = 1;
  localparam int unsigned C2_LEARN_DIS_BIT = 0;
  // reset values of the bits that do not come from straps
  localparam logic [7:0] C1_FIXED_RESET = 8'h00;
  localparam logic [7:0] C2_FIXED_RESET = 8'h06;
  localparam logic       P3_FORCE_FC_RESET = 1'h0;
  // default tag layout: pcp[15:13], cfi[12], vid[11:0]
  localparam int unsigned TAG_PCP_LSB = 13;
  localparam int unsigned TAG_CFI_BIT = 12;
  localparam int unsigned TAG_VID_W   = 12;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
endpackage

/* hdl/spc_port_ctrl.sv */
// spc_port_ctrl: per-port control registers 1 and 2 of a three-port switch, plus the
// per-packet decisions they steer (egress mask, mirroring, filtering, tagging, learning).
// assumes a synchronous 8-bit register port, straps stable while rst_in is high,
// and default tags supplied by the neighbouring control-3/4 registers.
//
// Behaviour
// - each port has its own control 1 at 0x11, 0x21, 0x31, same layout.
// - control 1 bit 7 makes the port the mirroring destination; reset 0.
// - control 1 bit 6 mirrors every received, undropped packet to a sniffer in its membership; reset 0.
// - control 1 bit 5 mirrors every transmitted, undropped packet to a sniffer in the ingress membership; reset 0.
// - control 1 bit 4 adds ingress default tag to every packet; else none.
// - bits 2-0 are egress membership; bit 2 port 3, bit 0 port 1.
// - a port forwards only to ports set in its own membership field.
// - own membership bit resets to 1, the other two from straps.
// - control 2 sits at 0x12, 0x22, 0x32; bit 7 reads zero.
// - control 2 bit 6 drops ingress packets whose VLAN members exclude the port.
// - control 2 bit 5 drops packets whose VLAN id differs from default id.
// - control 2 bit 4 forces flow control on; ports 1, 2 reset from straps.
// - with force clear, flow control follows auto-negotiation result.
// - on port 3 the force bit is ignored; global flow bit governs it.
// - control 2 bit 3 enables half-duplex back pressure; reset from strap.
// - control 2 bit 2 gates transmission; reset 1.
// - control 2 bit 1 gates reception; reset 1.
// - control 2 bit 0 stops source address learning; reset 0.
// - default tag carries 3-bit priority, CFI bit and 12-bit VLAN id.
`timescale 1ns/100ps
module spc_port_ctrl #(
  parameter int unsigned PORTS = spc_pkg::NUM_PORTS
) (
  input  wire logic              sys_clk_in,                 // 20 MHz switch clock
  input  wire logic              rst_in,                     // synchronous reset, active high
  input  wire logic [7:0]        reg_addr_in,                // register offset
  input  wire logic [7:0]        reg_wdata_in,               // write data
  input  wire logic              reg_wr_in,                  // write strobe
  input  wire logic              reg_rd_in,                  // read strobe
  output logic      [7:0]        reg_rdata_out,              // read data, one cycle after reg_rd_in
  input  wire logic              strap_p1_member_to_p3_in,   // membership strap
  input  wire logic              strap_p1_member_to_p2_in,   // membership strap
  input  wire logic              strap_p2_member_to_p3_in,   // membership strap
  input  wire logic              strap_p2_member_to_p1_in,   // membership strap
  input  wire logic              strap_p3_member_to_p2_in,   // membership strap
  input  wire logic              strap_p3_member_to_p1_in,   // membership strap
  input  wire logic              strap_port1_forced_flowctl_in, // forced flow strap, port 1
  input  wire logic              strap_port2_forced_flowctl_in, // forced flow strap, port 2
  input  wire logic              strap_backpressure_on_in,   // back pressure strap, all ports
  input  wire logic [PORTS-1:0]  auto_negotiation_fc_in,     // negotiated pause result per port
  input  wire logic              global_p3_flowctl_in,       // global flow control bit for port 3
  input  wire logic [16*PORTS-1:0] port_default_tag_in,      // default tags, port 1 in low bits
  input  wire logic              pkt_valid_in,               // packet lookup request
  input  wire logic [1:0]        pkt_ingress_in,             // ingress port index 0..2
  input  wire logic [PORTS-1:0]  pkt_dest_in,                // lookup destination mask
  input  wire logic [11:0]       pkt_vlan_identifier_in,     // packet VLAN id
  input  wire logic [PORTS-1:0]  pkt_vlan_member_in,         // VLAN table members [18:16]
  output logic                   dec_valid_out,              // decision valid
  output logic [PORTS-1:0]       dec_fwd_mask_out,           // final egress ports
  output logic                   dec_drop_out,               // packet discarded
  output logic                   dec_monitored_out,          // packet marked monitored
  output logic                   dec_add_tag_out,            // add a tag on egress
  output logic [15:0]            dec_tag_out,                // tag to add
  output logic                   dec_learn_out,              // source address may be learned
  output logic [PORTS-1:0]       flowctl_enable_out,         // effective flow control per port
  output logic [PORTS-1:0]       backpressure_out,           // half-duplex back pressure per port
  output logic [PORTS-1:0]       tx_enable_out,              // transmission enable per port
  output logic [PORTS-1:0]       rx_enable_out               // reception enable per port
);

  logic [7:0] ctrl1_reg [PORTS];
  logic [7:0] ctrl2_reg [PORTS];

  // returns the port index of a control-1 or control-2 offset, PORTS when unmapped
  function automatic logic [1:0] port_of(input logic [7:0] addr, input logic second);
    logic [1:0] idx;
    idx = 2'(PORTS);
    case (addr)
      spc_pkg::P1_MIRROR_VLAN_CTRL_OFS: if (!second) idx = 2'h0;
      spc_pkg::P2_MIRROR_VLAN_CTRL_OFS: if (!second) idx = 2'h1;
      spc_pkg::P3_MIRROR_VLAN_CTRL_OFS: if (!second) idx = 2'h2;
      spc_pkg::P1_FILTER_FLOW_CTRL_OFS: if (second) idx = 2'h0;
      spc_pkg::P2_FILTER_FLOW_CTRL_OFS: if (second) idx = 2'h1;
      spc_pkg::P3_FILTER_FLOW_CTRL_OFS: if (second) idx = 2'h2;
      default: idx = 2'(PORTS);
    endcase
    return idx;
  endfunction

  logic [1:0] wr1_idx;
  logic [1:0] wr2_idx;
  logic [1:0] rd1_idx;
  logic [1:0] rd2_idx;
  assign wr1_idx = port_of(reg_addr_in, 1'b0);
  assign wr2_idx = port_of(reg_addr_in, 1'b1);
  assign rd1_idx = wr1_idx;
  assign rd2_idx = wr2_idx;

  // strap sets for the two non-own membership bits of each port
  logic [2:0] member_strap [PORTS];
  assign member_strap[0] = {strap_p1_member_to_p3_in, strap_p1_member_to_p2_in, 1'b1};
  assign member_strap[1] = {strap_p2_member_to_p3_in, 1'b1, strap_p2_member_to_p1_in};
  assign member_strap[2] = {1'b1, strap_p3_member_to_p2_in, strap_p3_member_to_p1_in};

  logic [PORTS-1:0] force_fc_strap;
  assign force_fc_strap = {spc_pkg::P3_FORCE_FC_RESET, strap_port2_forced_flowctl_in,
                           strap_port1_forced_flowctl_in};

  // control 1; straps are sampled on every edge while reset is held, so the last one wins
  always_ff @(posedge sys_clk_in) begin
    for (int p = 0; p < PORTS; p++) begin
      if (rst_in) begin
        ctrl1_reg[p] <= spc_pkg::C1_FIXED_RESET | {5'h00, member_strap[p]};
      end else if (reg_wr_in && wr1_idx == 2'(p)) begin
        ctrl1_reg[p] <= reg_wdata_in;
      end
    end
  end

  // control 2
  always_ff @(posedge sys_clk_in) begin
    for (int p = 0; p < PORTS; p++) begin
      if (rst_in) begin
        ctrl2_reg[p] <= spc_pkg::C2_FIXED_RESET;
        ctrl2_reg[p][spc_pkg::C2_FORCE_FC_BIT] <= force_fc_strap[p];
        ctrl2_reg[p][spc_pkg::C2_BACKPRES_BIT] <= strap_backpressure_on_in;
      end else if (reg_wr_in && wr2_idx == 2'(p)) begin
        ctrl2_reg[p] <= reg_wdata_in;
        ctrl2_reg[p][spc_pkg::C2_RSVD_BIT] <= 1'b0;
      end
    end
  end

  // read path; unmapped offsets answer zero
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      reg_rdata_out <= spc_pkg::UNMAPPED_READ;
    end else if (reg_rd_in) begin
      if (rd1_idx < 2'(PORTS)) begin
        reg_rdata_out <= ctrl1_reg[rd1_idx];
      end else if (rd2_idx < 2'(PORTS)) begin
        reg_rdata_out <= ctrl2_reg[rd2_idx];
      end else begin
        reg_rdata_out <= spc_pkg::UNMAPPED_READ;
      end
    end
  end

  // per-port level controls
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      flowctl_enable_out <= '0;
      backpressure_out   <= '0;
      tx_enable_out      <= '0;
      rx_enable_out      <= '0;
    end else begin
      for (int p = 0; p < PORTS; p++) begin
        if (p == PORTS - 1) begin
          flowctl_enable_out[p] <= global_p3_flowctl_in;
        end else begin
          flowctl_enable_out[p] <= ctrl2_reg[p][spc_pkg::C2_FORCE_FC_BIT]
                                   | auto_negotiation_fc_in[p];
        end
        backpressure_out[p] <= ctrl2_reg[p][spc_pkg::C2_BACKPRES_BIT];
        tx_enable_out[p]    <= ctrl2_reg[p][spc_pkg::C2_TX_EN_BIT];
        rx_enable_out[p]    <= ctrl2_reg[p][spc_pkg::C2_RX_EN_BIT];
      end
    end
  end

  // per-packet decision, combinational, registered below
  logic [1:0]       ing;
  logic [7:0]       ing_c1;
  logic [7:0]       ing_c2;
  logic [15:0]      ing_tag;
  logic [PORTS-1:0] member_mask;
  logic [PORTS-1:0] sniffer_mask;
  logic [PORTS-1:0] tx_sniff_mask;
  logic [PORTS-1:0] tx_en_mask;
  logic [PORTS-1:0] base_mask;
  logic             monitored;
  logic             drop;
  logic [PORTS-1:0] fwd_mask;

  // an out-of-range ingress index falls back to port 1 rather than reading past the array
  assign ing     = (pkt_ingress_in < 2'(PORTS)) ? pkt_ingress_in : 2'h0;
  assign ing_c1  = ctrl1_reg[ing];
  assign ing_c2  = ctrl2_reg[ing];
  assign ing_tag = port_default_tag_in[16*ing +: 16];
  assign member_mask = ing_c1[spc_pkg::C1_MEMBER_LSB +: spc_pkg::C1_MEMBER_W];

  always_comb begin
    sniffer_mask  = '0;
    tx_sniff_mask = '0;
    tx_en_mask    = '0;
    for (int p = 0; p < PORTS; p++) begin
      sniffer_mask[p]  = ctrl1_reg[p][spc_pkg::C1_SNIFFER_BIT];
      tx_sniff_mask[p] = ctrl1_reg[p][spc_pkg::C1_TX_SNIFF_BIT];
      tx_en_mask[p]    = ctrl2_reg[p][spc_pkg::C2_TX_EN_BIT];
    end
  end

  always_comb begin
    drop = !ing_c2[spc_pkg::C2_RX_EN_BIT];
    if (ing_c2[spc_pkg::C2_IN_FILTER_BIT] && !pkt_vlan_member_in[ing]) begin
      drop = 1'b1;
    end
    if (ing_c2[spc_pkg::C2_DROP_NPVID_BIT]
        && pkt_vlan_identifier_in != ing_tag[spc_pkg::TAG_VID_W-1:0]) begin
      drop = 1'b1;
    end
    base_mask = pkt_dest_in & tx_en_mask;
    monitored = ing_c1[spc_pkg::C1_RX_SNIFF_BIT]
                | (|(base_mask & member_mask & tx_sniff_mask));
    fwd_mask  = base_mask;
    if (monitored) begin
      fwd_mask = fwd_mask | (sniffer_mask & tx_en_mask);
    end
    // the ingress port never receives its own packet, and excluded ports never see it
    fwd_mask = fwd_mask & member_mask & ~(PORTS'(1) << ing);
    if (drop) begin
      fwd_mask = '0;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      dec_valid_out     <= 1'b0;
      dec_fwd_mask_out  <= '0;
      dec_drop_out      <= 1'b0;
      dec_monitored_out <= 1'b0;
      dec_add_tag_out   <= 1'b0;
      dec_tag_out       <= 16'h0000;
      dec_learn_out     <= 1'b0;
    end else begin
      dec_valid_out     <= pkt_valid_in;
      dec_fwd_mask_out  <= pkt_valid_in ? fwd_mask : '0;
      dec_drop_out      <= pkt_valid_in & drop;
      dec_monitored_out <= pkt_valid_in & monitored & !drop;
      dec_add_tag_out   <= pkt_valid_in & ing_c1[spc_pkg::C1_DBL_TAG_BIT];
      dec_tag_out       <= ing_tag;
      dec_learn_out     <= pkt_valid_in & !drop & !ing_c2[spc_pkg::C2_LEARN_DIS_BIT];
    end
  end

endmodule

/* sim/spc_port_ctrl_sva.sv */
// spc_port_ctrl_sva: port-level timing and consistency checks for spc_port_ctrl
// assumes the single switch clock and the synchronous active-high reset of the design
`timescale 1ns/100ps
module spc_port_ctrl_sva #(
  parameter int unsigned PORTS = spc_pkg::NUM_PORTS
) (
  input wire logic                 sys_clk_in,
  input wire logic                 rst_in,
  input wire logic                 reg_rd_in,
  input wire logic [7:0]           reg_rdata_out,
  input wire logic [PORTS-1:0]     auto_negotiation_fc_in,
  input wire logic                 global_p3_flowctl_in,
  input wire logic [16*PORTS-1:0]  port_default_tag_in,
  input wire logic                 pkt_valid_in,
  input wire logic [1:0]           pkt_ingress_in,
  input wire logic                 dec_valid_out,
  input wire logic [PORTS-1:0]     dec_fwd_mask_out,
  input wire logic                 dec_drop_out,
  input wire logic                 dec_monitored_out,
  input wire logic                 dec_add_tag_out,
  input wire logic [15:0]          dec_tag_out,
  input wire logic                 dec_learn_out,
  input wire logic [PORTS-1:0]     flowctl_enable_out
);
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (rst_in);
  sequence s_req_p1;
    pkt_valid_in && pkt_ingress_in == 2'h0;
  endsequence
  sequence s_req_p2;
    pkt_valid_in && pkt_ingress_in == 2'h1;
  endsequence
  a_dec_one_later: assert property (pkt_valid_in |=> dec_valid_out)
    else $error("decision missing one cycle after request");
  a_dec_no_spurious: assert property (!pkt_valid_in |=> !dec_valid_out)
    else $error("decision without request");
  a_dec_idle_zero: assert property (!dec_valid_out |-> dec_fwd_mask_out == '0 && !dec_drop_out && !dec_learn_out)
    else $error("decision fields set while idle");
  a_drop_clears_all: assert property (dec_drop_out |-> dec_fwd_mask_out == '0 && !dec_learn_out && !dec_monitored_out)
    else $error("dropped packet still forwarded or learned");
  a_ingress_not_echoed: assert property (s_req_p2 |=> !dec_fwd_mask_out[1])
    else $error("packet sent back to its ingress port");
  a_tag_from_ingress: assert property (s_req_p1 |=> dec_tag_out == $past(port_default_tag_in[15:0]))
    else $error("tag is not the ingress default tag");
  a_rdata_holds: assert property (!reg_rd_in |=> $stable(reg_rdata_out))
    else $error("read data changed without a read");
  a_port3_flow_global: assert property (!$past(rst_in, 2) |-> flowctl_enable_out[2] == $past(global_p3_flowctl_in))
    else $error("port 3 flow control not following global bit");
  a_port1_flow_an: assert property (!$past(rst_in, 2) && $past(auto_negotiation_fc_in[0]) |-> flowctl_enable_out[0])
    else $error("negotiated flow control not enabled on port 1");
endmodule
bind spc_port_ctrl spc_port_ctrl_sva #(.PORTS(PORTS)) spc_port_ctrl_sva_i (.sys_clk_in, .rst_in, .reg_rd_in,
  .reg_rdata_out, .auto_negotiation_fc_in, .global_p3_flowctl_in, .port_default_tag_in, .pkt_valid_in,
  .pkt_ingress_in, .dec_valid_out, .dec_fwd_mask_out, .dec_drop_out, .dec_monitored_out, .dec_add_tag_out,
  .dec_tag_out, .dec_learn_out, .flowctl_enable_out);

/* sim/tb.sv */
// tb: self-checking bench for spc_port_ctrl through its register port and packet decision port
// assumes one-cycle read and decision latency; straps change only after reset to prove they are held
`timescale 1ns/100ps
module tb;
  logic        sys_clk_in = 1'h0, rst_in = 1'h1, reg_wr_in = 1'h0, reg_rd_in = 1'h0, pkt_valid_in = 1'h0;
  logic [7:0]  reg_addr_in = 8'h00, reg_wdata_in = 8'h00, reg_rdata_out;
  logic        strap_p1_member_to_p3_in = 1'h1, strap_p1_member_to_p2_in = 1'h0, strap_p2_member_to_p3_in = 1'h0;
  logic        strap_p2_member_to_p1_in = 1'h1, strap_p3_member_to_p2_in = 1'h1, strap_p3_member_to_p1_in = 1'h0;
  logic        strap_port1_forced_flowctl_in = 1'h1, strap_port2_forced_flowctl_in = 1'h0;
  logic        strap_backpressure_on_in = 1'h1, global_p3_flowctl_in = 1'h1;
  logic [2:0]  auto_negotiation_fc_in = 3'h0, pkt_dest_in = 3'h0, pkt_vlan_member_in = 3'h0;
  logic [47:0] port_default_tag_in = 48'h6003_4002_2001;
  logic [1:0]  pkt_ingress_in = 2'h0;
  logic [11:0] pkt_vlan_identifier_in = 12'h000;
  logic        dec_valid_out, dec_drop_out, dec_monitored_out, dec_add_tag_out, dec_learn_out;
  logic [2:0]  dec_fwd_mask_out, flowctl_enable_out, backpressure_out, tx_enable_out, rx_enable_out;
  logic [15:0] dec_tag_out;
  int          num_errors = 0, n_compared = 0;
  logic [7:0]  ofs [6] = '{spc_pkg::P1_MIRROR_VLAN_CTRL_OFS, spc_pkg::P1_FILTER_FLOW_CTRL_OFS,
    spc_pkg::P2_MIRROR_VLAN_CTRL_OFS, spc_pkg::P2_FILTER_FLOW_CTRL_OFS,
    spc_pkg::P3_MIRROR_VLAN_CTRL_OFS, spc_pkg::P3_FILTER_FLOW_CTRL_OFS};
  logic [7:0]  rst_exp [6] = '{8'h05, 8'h1E, 8'h03, 8'h0E, 8'h06, 8'h0E};
  spc_port_ctrl spc_port_ctrl_i (.sys_clk_in, .rst_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in,
    .reg_rdata_out, .strap_p1_member_to_p3_in, .strap_p1_member_to_p2_in, .strap_p2_member_to_p3_in,
    .strap_p2_member_to_p1_in, .strap_p3_member_to_p2_in, .strap_p3_member_to_p1_in,
    .strap_port1_forced_flowctl_in, .strap_port2_forced_flowctl_in, .strap_backpressure_on_in,
    .auto_negotiation_fc_in, .global_p3_flowctl_in, .port_default_tag_in, .pkt_valid_in, .pkt_ingress_in,
    .pkt_dest_in, .pkt_vlan_identifier_in, .pkt_vlan_member_in, .dec_valid_out, .dec_fwd_mask_out,
    .dec_drop_out, .dec_monitored_out, .dec_add_tag_out, .dec_tag_out, .dec_learn_out,
    .flowctl_enable_out, .backpressure_out, .tx_enable_out, .rx_enable_out);
  always #25 sys_clk_in = ~sys_clk_in;
  task automatic step;
    @(posedge sys_clk_in);
    #1;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // strobes drop for a full cycle so back-to-back calls never touch one signal twice in a step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr_in = a;
    reg_wdata_in = d;
    reg_wr_in = 1'h1;
    step;
    reg_wr_in = 1'h0;
    step;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    reg_addr_in = a;
    reg_rd_in = 1'h1;
    step;
    reg_rd_in = 1'h0;
    chk(reg_rdata_out, e);
    step;
  endtask
  // flags are {drop, monitored, learn, add_tag}
  task automatic pkt(input logic [1:0] ing, input logic [2:0] dst, input logic [11:0] vlan_identifier,
                     input logic [2:0] mem, input logic [2:0] emask, input logic [3:0] eflags);
    pkt_ingress_in = ing;
    pkt_dest_in = dst;
    pkt_vlan_identifier_in = vlan_identifier;
    pkt_vlan_member_in = mem;
    pkt_valid_in = 1'h1;
    step;
    pkt_valid_in = 1'h0;
    chk({dec_valid_out, dec_fwd_mask_out, dec_drop_out, dec_monitored_out, dec_learn_out, dec_add_tag_out},
        {1'h1, emask, eflags});
    chk(dec_tag_out, port_default_tag_in[16*int'(ing) +: 16]);
    step;
  endtask
  task automatic t_reset_vals;
    strap_p1_member_to_p3_in = 1'h0;
    strap_port1_forced_flowctl_in = 1'h0;
    strap_backpressure_on_in = 1'h0;
    for (int i = 0; i < 6; i++) rdc(ofs[i], rst_exp[i]);
    rdc(8'h13, 8'h00);
  endtask
  task automatic t_levels;
    chk({flowctl_enable_out, backpressure_out, tx_enable_out, rx_enable_out}, 12'hBFF);
    wr(ofs[1], 8'h00);
    chk({flowctl_enable_out, backpressure_out, tx_enable_out, rx_enable_out}, 12'h9B6);
    auto_negotiation_fc_in = 3'h7;
    global_p3_flowctl_in = 1'h0;
    wr(ofs[5], 8'h1E);
    chk({flowctl_enable_out, backpressure_out, tx_enable_out, rx_enable_out}, 12'h7B6);
  endtask
  task automatic t_rw;
    for (int i = 0; i < 6; i++) begin
      wr(ofs[i], 8'hFF);
      rdc(ofs[i], i[0] ? 8'h7F : 8'hFF);
    end
    wr(8'h40, 8'h5A);
    rdc(8'h40, 8'h00);
  endtask
  task automatic t_packets;
    for (int i = 0; i < 6; i++) wr(ofs[i], i[0] ? 8'h06 : 8'h07);
    pkt(2'h0, 3'h7, 12'h001, 3'h7, 3'h6, 4'h2);
    wr(ofs[2], 8'h01);
    pkt(2'h1, 3'h7, 12'h002, 3'h7, 3'h1, 4'h2);
    wr(ofs[2], 8'h07);
    wr(ofs[1], 8'h04);
    pkt(2'h0, 3'h7, 12'h001, 3'h7, 3'h0, 4'h8);
    wr(ofs[1], 8'h46);
    pkt(2'h0, 3'h7, 12'h001, 3'h6, 3'h0, 4'h8);
    pkt(2'h0, 3'h7, 12'h001, 3'h1, 3'h6, 4'h2);
    wr(ofs[1], 8'h26);
    pkt(2'h0, 3'h7, 12'h005, 3'h7, 3'h0, 4'h8);
    pkt(2'h0, 3'h7, 12'h001, 3'h7, 3'h6, 4'h2);
    wr(ofs[1], 8'h07);
    pkt(2'h0, 3'h7, 12'h001, 3'h7, 3'h6, 4'h0);
    wr(ofs[1], 8'h06);
    wr(ofs[5], 8'h02);
    pkt(2'h0, 3'h7, 12'h001, 3'h7, 3'h2, 4'h2);
    wr(ofs[5], 8'h06);
    wr(ofs[0], 8'h47);
    wr(ofs[4], 8'h87);
    pkt(2'h0, 3'h2, 12'h001, 3'h7, 3'h6, 4'h6);
    wr(ofs[0], 8'h07);
    pkt(2'h0, 3'h2, 12'h001, 3'h7, 3'h2, 4'h2);
    wr(ofs[2], 8'h27);
    pkt(2'h0, 3'h2, 12'h001, 3'h7, 3'h6, 4'h6);
    wr(ofs[2], 8'h07);
    wr(ofs[0], 8'h17);
    pkt(2'h0, 3'h2, 12'h001, 3'h7, 3'h2, 4'h3);
  endtask
  task automatic finish_test;
    if (num_errors == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    #(1000 * 50);
    num_errors++;
    finish_test;
  end
  initial begin
    repeat (3) @(posedge sys_clk_in);
    #1;
    rst_in = 1'h0;
    step;
    step;
    t_reset_vals;
    t_levels;
    t_rw;
    t_packets;
    finish_test;
  end
endmodule
